// File: logic/aeu_defines.vh
// Constants for the accumulator extract unit.
// Assumes inclusion by bare name from the logic folder.
`ifndef AEU_DEFINES_VH
`define AEU_DEFINES_VH

// Operation codes, one bit each; variable forms also set bit 5
`define AEU_OP_W            8'h01
`define AEU_OP_W_R          8'h02
`define AEU_OP_W_RS         8'h04
`define AEU_OP_H_S          8'h08
`define AEU_OP_FIELD        8'h10
`define AEU_OP_WV           8'h21
`define AEU_OP_WV_R         8'h22
`define AEU_OP_WV_RS        8'h24

// Operation code bits
`define AEU_OPB_W           0
`define AEU_OPB_R           1
`define AEU_OPB_RS          2
`define AEU_OPB_H           3
`define AEU_OPB_FIELD       4
`define AEU_OPB_VAR         5

// Control register layout
`define AEU_CTL_POS_HI      5
`define AEU_CTL_POS_LO      0
`define AEU_CTL_EFI         14
`define AEU_CTL_SAT         23
`define AEU_CTL_RESET       32'h00000000

// Source operand field holding size or shift
`define AEU_SRC_HI          4
`define AEU_SRC_LO          0

// Result and field mask constants
`define AEU_DEST_RESET      32'h00000000
`define AEU_FIELD_SEED      32'hFFFFFFFE

// Saturation values
`define AEU_Q31_MAX         32'h7FFFFFFF
`define AEU_Q31_MIN         32'h80000000
`define AEU_H_MAX           32'h00007FFF
`define AEU_H_MIN           32'hFFFF8000
`define AEU_H_MAX64         64'h0000000000007FFF
`define AEU_H_MIN64         64'hFFFFFFFFFFFF8000

`endif

// File: logic/aeu_word_shift.v
// Word extract path: shift, round, overflow detect, saturate.
// Assumes accumulator and shift are stable in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defines.vh"

module aeu_word_shift (
    // Operands
    input  wire [63:0] acc,
    input  wire [4:0]  shift,
    input  wire        do_round,
    input  wire        do_sat,
    // Result
    output reg  [31:0] result,
    output reg         ovf
);
    reg [64:0] temp;
    reg [64:0] rnd;
    reg        ovf_a;
    reg        ovf_b;

    always @* begin
        // Extra bit below the result; zero when shift is zero
        temp = $signed({acc, 1'b0}) >>> shift; // [RULE9] [RULE8]
        rnd = temp + 65'h00000000000000001; // [RULE10]
        ovf_a = ~((&temp[64:32]) | ~(|temp[64:32])); // [RULE13]
        ovf_b = ~((&rnd[64:32]) | ~(|rnd[64:32])); // [RULE13]
        ovf = ovf_a | ovf_b; // [RULE14]
        if (!do_round) begin
            result = temp[32:1]; // [RULE8]
        end else if (do_sat && ovf_b) begin
            // Sign of rounded intermediate picks the clamp
            result = rnd[64] ? `AEU_Q31_MIN : `AEU_Q31_MAX; // [RULE11] [RULE12]
        end else begin
            result = rnd[32:1]; // [RULE10]
        end
    end
endmodule // aeu_word_shift

`default_nettype wire

// File: logic/aeu_half_sat.v
// Halfword extract path: arithmetic shift then 16-bit saturation.
// Assumes accumulator and shift are stable in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defines.vh"

module aeu_half_sat (
    // Operands
    input  wire [63:0] acc,
    input  wire [4:0]  shift,
    // Result
    output reg  [31:0] result,
    output reg         sat
);
    reg [63:0] temp;

    always @* begin
        temp = $signed(acc) >>> shift; // [RULE15]
        // Sign mismatch at bit 31 flags too, without clamping
        sat = (acc[63] != temp[31]); // [RULE18]
        if ($signed(temp) > $signed(`AEU_H_MAX64)) begin
            result = `AEU_H_MAX; // [RULE16]
            sat = 1'b1; // [RULE17]
        end else if ($signed(temp) < $signed(`AEU_H_MIN64)) begin
            result = `AEU_H_MIN; // [RULE16]
            sat = 1'b1; // [RULE17]
        end else begin
            result = temp[31:0]; // [RULE15]
        end
    end
endmodule // aeu_half_sat

`default_nettype wire

// File: logic/aeu_extract_unit.v
// Accumulator extract unit: one request a cycle, result one cycle later.
// Assumes the pipeline holds the accumulators and the control register.
//
// Overview of operation
// [RULE1] Field extract valid only when start minus (size plus one) is at least -1.
// [RULE2] Extract fail flag bit 14 written 1 on failure, 0 on success.
// [RULE3] Field extract never changes the position field, bits 0 to 5.
// [RULE4] Field size is low five bits of source operand, unsigned.
// [RULE5] Valid field: size+1 bits from start downward, zero-extended to 32.
// [RULE6] Index picks one of four accumulators; none is ever modified.
// [RULE7] No extract raises a data-dependent exception.
// [RULE8] Word extract: arithmetic right shift, low 32 bits written.
// [RULE9] Shift keeps one extra low bit; result is intermediate bits 32..1.
// [RULE10] Rounding adds one at the top discarded bit.
// [RULE11] Rounding saturating extract clamps positive overflow to 0x7FFFFFFF.
// [RULE12] Negative overflow clamps to 0x80000000.
// [RULE13] Overflow when bits 64..32 not all equal, before and after rounding.
// [RULE14] Every word extract sets saturation flag bit 23 on either overflow.
// [RULE15] Halfword extract: shift, saturate to 16 bits, sign-extend.
// [RULE16] Halfword clamps to 0x00007FFF and 0xFFFF8000.
// [RULE17] Halfword clamping sets the saturation flag.
// [RULE18] Halfword sets flag when shifted bit 31 differs from sign.
// [RULE19] Variable word shifts take low five bits of source operand.
// [RULE20] Extracts check DSP access first and trap when not permitted.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defines.vh"

module aeu_extract_unit (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Request
    input  wire        req_valid,
    input  wire [7:0]  op,
    input  wire [1:0]  sum_register_index,
    input  wire [4:0]  shift_imm,
    input  wire [31:0] source_operand_reg,
    input  wire        dsp_access_ok,
    input  wire        dsp_implemented,
    // Accumulators, upper and bottom words
    input  wire [31:0] acc_upper_word0,
    input  wire [31:0] acc_bottom_word0,
    input  wire [31:0] acc_upper_word1,
    input  wire [31:0] acc_bottom_word1,
    input  wire [31:0] acc_upper_word2,
    input  wire [31:0] acc_bottom_word2,
    input  wire [31:0] acc_upper_word3,
    input  wire [31:0] acc_bottom_word3,
    // Control register, current value
    input  wire [31:0] dsp_control_reg,
    // Result
    output reg         res_valid,
    output reg  [31:0] dest_operand_reg,
    output reg         dest_write,
    output reg  [31:0] next_dsp_control,
    output reg         ctl_write,
    output reg         exc_reserved,
    output reg         exc_dsp_disabled
);
    reg         rst_meta;
    reg         rst_sync_n;
    reg  [63:0] acc;
    reg  [4:0]  shift;
    reg  [31:0] next_dest;
    reg  [31:0] next_ctl;
    reg         field_ok;
    reg  [6:0]  field_end;
    reg  [63:0] field_shifted;
    reg  [31:0] field_mask;
    wire [31:0] word_res;
    wire        word_ovf;
    wire [31:0] half_res;
    wire        half_sat;
    wire        known_op;
    wire        allowed;
    wire [4:0]  field_size;

    // Reset released through two flops
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Read-only selection; accumulators are never written here
    always @* begin
        case (sum_register_index) // [RULE6]
            2'h0: acc = {acc_upper_word0, acc_bottom_word0};
            2'h1: acc = {acc_upper_word1, acc_bottom_word1};
            2'h2: acc = {acc_upper_word2, acc_bottom_word2};
            default: acc = {acc_upper_word3, acc_bottom_word3};
        endcase
    end

    // Variable forms use the source operand, upper bits ignored
    always @* begin
        if (op[`AEU_OPB_VAR]) begin
            shift = source_operand_reg[`AEU_SRC_HI:`AEU_SRC_LO]; // [RULE19]
        end else begin
            shift = shift_imm;
        end
    end

    assign known_op = (op == `AEU_OP_W) || (op == `AEU_OP_W_R) || (op == `AEU_OP_W_RS) ||
                      (op == `AEU_OP_H_S) || (op == `AEU_OP_FIELD) || (op == `AEU_OP_WV) ||
                      (op == `AEU_OP_WV_R) || (op == `AEU_OP_WV_RS);
    // Traps depend only on access state and operation code, never on data
    assign allowed = dsp_implemented && dsp_access_ok; // [RULE20] [RULE7]
    assign field_size = source_operand_reg[`AEU_SRC_HI:`AEU_SRC_LO]; // [RULE4]

    aeu_word_shift u_word (
        .acc      (acc),
        .shift    (shift),
        .do_round (op[`AEU_OPB_R] | op[`AEU_OPB_RS]),
        .do_sat   (op[`AEU_OPB_RS]),
        .result   (word_res),
        .ovf      (word_ovf)
    );

    aeu_half_sat u_half (
        .acc    (acc),
        .shift  (shift_imm),
        .result (half_res),
        .sat    (half_sat)
    );

    // Field extract
    always @* begin
        // pos - (size+1) >= -1 is pos >= size
        field_ok = ({1'b0, dsp_control_reg[`AEU_CTL_POS_HI:`AEU_CTL_POS_LO]} >=
                    {2'b00, field_size}); // [RULE1]
        field_end = {1'b0, dsp_control_reg[`AEU_CTL_POS_HI:`AEU_CTL_POS_LO]} -
                    {2'b00, field_size};
        field_shifted = acc >> field_end[5:0]; // [RULE5]
        field_mask = ~(`AEU_FIELD_SEED << field_size); // [RULE5]
    end

    always @* begin
        next_dest = 32'h00000000;
        next_ctl = dsp_control_reg;
        if (op[`AEU_OPB_FIELD]) begin
            // Position field left as is either way
            next_ctl[`AEU_CTL_EFI] = ~field_ok; // [RULE2] [RULE3]
            // Failed result is unspecified; zero is written
            next_dest = field_ok ? (field_shifted[31:0] & field_mask) : 32'h00000000; // [RULE5]
        end else if (op[`AEU_OPB_H]) begin
            next_dest = half_res; // [RULE15]
            if (half_sat) begin
                next_ctl[`AEU_CTL_SAT] = 1'b1; // [RULE17] [RULE18]
            end
        end else begin
            next_dest = word_res;
            if (word_ovf) begin
                next_ctl[`AEU_CTL_SAT] = 1'b1; // [RULE14]
            end
        end
    end

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            res_valid <= 1'b0;
            dest_operand_reg <= `AEU_DEST_RESET;
            dest_write <= 1'b0;
            next_dsp_control <= `AEU_CTL_RESET;
            ctl_write <= 1'b0;
            exc_reserved <= 1'b0;
            exc_dsp_disabled <= 1'b0;
        end else begin
            res_valid <= req_valid;
            exc_reserved <= req_valid && (!dsp_implemented || !known_op); // [RULE20]
            exc_dsp_disabled <= req_valid && dsp_implemented && known_op && !dsp_access_ok; // [RULE20]
            dest_write <= req_valid && known_op && allowed;
            ctl_write <= req_valid && known_op && allowed;
            if (req_valid && known_op && allowed) begin
                dest_operand_reg <= next_dest;
                next_dsp_control <= next_ctl;
            end
        end
    end
endmodule // aeu_extract_unit

`default_nettype wire

// File: verif/aeu_extract_props.sv
// Checker for the extract unit, bound to its top module.
// Assumes no request before the internal reset copy is released.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defines.vh"
module aeu_extract_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Request
    input wire logic        req_valid,
    input wire logic [7:0]  op,
    input wire logic [31:0] source_operand_reg,
    input wire logic        dsp_access_ok,
    input wire logic        dsp_implemented,
    input wire logic [31:0] dsp_control_reg,
    // Result
    input wire logic        dest_write,
    input wire logic [31:0] dest_operand_reg,
    input wire logic [31:0] next_dsp_control,
    input wire logic        ctl_write,
    input wire logic        exc_reserved,
    input wire logic        exc_dsp_disabled,
    input wire logic        res_valid
);
    // Request copies, so each result is judged against its own cause
    logic [7:0]  op_q;
    logic [31:0] src_q;
    logic [31:0] ctl_q;
    always @(posedge clock) begin
        op_q <= op;
        src_q <= source_operand_reg;
        ctl_q <= dsp_control_reg;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_answer_next: assert property (req_valid |=> res_valid)
        else $error("no answer after request");
    a_trap_no_write: assert property ((exc_reserved || exc_dsp_disabled) |-> !dest_write && !ctl_write)
        else $error("write during trap");
    a_access_trap: assert property (req_valid && dsp_implemented && !dsp_access_ok && op == `AEU_OP_W
        |=> exc_dsp_disabled && !exc_reserved)
        else $error("missing disabled trap");
    a_fail_flag: assert property (req_valid && op == `AEU_OP_FIELD && dsp_implemented
        && dsp_access_ok |=> ctl_write && next_dsp_control[14] == (ctl_q[5:0] < {1'b0, src_q[4:0]}))
        else $error("fail flag wrong");
    a_pos_kept: assert property (ctl_write && op_q == `AEU_OP_FIELD |-> next_dsp_control[5:0] == ctl_q[5:0])
        else $error("position field changed");
    a_field_zext: assert property (dest_write && op_q == `AEU_OP_FIELD && !next_dsp_control[14]
        |-> (dest_operand_reg >> ({1'b0, src_q[4:0]} + 6'd1)) == 32'h0)
        else $error("field not zero extended");
    a_sat_sticky: assert property (ctl_write && ctl_q[23] |-> next_dsp_control[23])
        else $error("sat flag cleared");
    a_half_range: assert property (dest_write && op_q == `AEU_OP_H_S
        |-> dest_operand_reg[31:15] == 17'h0 || dest_operand_reg[31:15] == 17'h1FFFF)
        else $error("half result out of range");
    c_trap: cover property (exc_reserved);
    c_fail: cover property (ctl_write && next_dsp_control[14]);
    c_sat: cover property (ctl_write && next_dsp_control[23] && !ctl_q[23]);
endmodule // aeu_extract_props
bind aeu_extract_unit aeu_extract_props i_props (.clock, .rst_n, .req_valid, .op, .source_operand_reg,
    .dsp_access_ok, .dsp_implemented, .dsp_control_reg, .dest_write, .dest_operand_reg, .next_dsp_control,
    .ctl_write, .exc_reserved, .exc_dsp_disabled, .res_valid);
`default_nettype wire

// File: verif/aeu_pipe_model.sv
// Pipeline model: accumulators and control register.
// Assumes the bench loads state between requests.
`timescale 1ns/1ps
`default_nettype none
module aeu_pipe_model (
    // Clock
    input  wire logic        clock,
    // Writeback
    input  wire logic        ctl_write,
    input  wire logic [31:0] next_dsp_control,
    // Bench load, one edge ahead of a request
    input  wire logic        ctl_load,
    input  wire logic [31:0] ctl_load_val,
    // State
    output logic     [255:0] acc_flat,
    output logic     [31:0]  dsp_control_reg
);
    logic [63:0] acc [0:3];
    // No write path into the accumulators
    assign acc_flat = {acc[3], acc[2], acc[1], acc[0]};
    always @(posedge clock) begin
        if (ctl_load) begin
            dsp_control_reg <= ctl_load_val;
        end else if (ctl_write) begin
            dsp_control_reg <= next_dsp_control;
        end
    end
endmodule // aeu_pipe_model
`default_nettype wire

// File: verif/aeu_extract_unit_tb.sv
// Self-checking bench for the extract unit.
// Assumes one request at a time, result one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defines.vh"
module aeu_extract_unit_tb;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic         req_valid = 1'b0;
    logic [7:0]   op = 8'h00;
    logic [1:0]   ix_r = 2'h0;
    logic [4:0]   shift_imm = 5'h00;
    logic [31:0]  src = 32'h0;
    logic         acc_ok = 1'b1;
    logic         impl = 1'b1;
    logic         ctl_load = 1'b0;
    logic [31:0]  ctl_val = 32'h0;
    logic [255:0] acc_flat;
    logic [31:0]  ctl, dest, next_ctl;
    logic         res_valid, dest_write, ctl_write, exc_res, exc_dis;
    logic [7:0]   ops [6] = '{`AEU_OP_W, `AEU_OP_W_R, `AEU_OP_W_RS, `AEU_OP_WV, `AEU_OP_WV_R, `AEU_OP_WV_RS};
    int           error_cnt = 0;
    int           n_compared = 0;
    always #50 clock = ~clock;
    aeu_pipe_model i_pipe (.clock, .ctl_write, .next_dsp_control(next_ctl), .ctl_load, .ctl_load_val(ctl_val),
        .acc_flat, .dsp_control_reg(ctl));
    aeu_extract_unit i_dut (.clock, .rst_n, .req_valid, .op, .sum_register_index(ix_r), .shift_imm,
        .source_operand_reg(src), .dsp_access_ok(acc_ok), .dsp_implemented(impl),
        .acc_upper_word0(acc_flat[63:32]), .acc_bottom_word0(acc_flat[31:0]),
        .acc_upper_word1(acc_flat[127:96]), .acc_bottom_word1(acc_flat[95:64]),
        .acc_upper_word2(acc_flat[191:160]), .acc_bottom_word2(acc_flat[159:128]),
        .acc_upper_word3(acc_flat[255:224]), .acc_bottom_word3(acc_flat[223:192]),
        .dsp_control_reg(ctl), .res_valid, .dest_operand_reg(dest), .dest_write,
        .next_dsp_control(next_ctl), .ctl_write, .exc_reserved(exc_res), .exc_dsp_disabled(exc_dis));
    task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Control value loaded one edge ahead, so the request edge sees it settled
    task automatic issue(input [7:0] o, input [1:0] ix, input [4:0] sh, input [31:0] s, input [31:0] c, input [3:0] ef);
        @(posedge clock);
        ctl_val <= c;
        ctl_load <= 1'b1;
        @(posedge clock);
        ctl_load <= 1'b0;
        op <= o;
        ix_r <= ix;
        shift_imm <= sh;
        src <= s;
        req_valid <= 1'b1;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        chk("flags", {28'h0, ef}, {28'h0, res_valid, dest_write, exc_res, exc_dis});
        @(posedge clock);
    endtask
    function automatic logic ov33(input [32:0] v);
        return v != 33'h0 && v != {33{1'b1}};
    endfunction
    task automatic t_field(input [5:0] pos, input [31:0] s);
        logic [63:0] ex;
        logic [31:0] c;
        // Old fail flag varies so both set and clear are seen
        c = 32'h0080_0000 | {17'h0, pos[0], 8'h00, pos};
        ex = (i_pipe.acc[0] >> (pos - {1'b0, s[4:0]})) & ((64'h1 << ({1'b0, s[4:0]} + 6'd1)) - 64'h1);
        issue(`AEU_OP_FIELD, 2'h0, 5'h1F, s, c, 4'hC);
        chk("ctl", {c[31:15], pos < {1'b0, s[4:0]}, c[13:0]}, next_ctl);
        if (pos >= {1'b0, s[4:0]}) chk("field", ex[31:0], dest);
    endtask
    task automatic t_word(input [7:0] o, input [1:0] ix, input [4:0] sh);
        logic [64:0] t;
        logic [64:0] u;
        logic [31:0] ex;
        t = (sh == 5'd0) ? {i_pipe.acc[ix], 1'b0} : {i_pipe.acc[ix][63], $signed(i_pipe.acc[ix]) >>> (sh - 5'd1)};
        u = t + 65'h1;
        ex = (o[1] | o[2]) ? u[32:1] : t[32:1];
        if (o[2] && ov33(u[64:32])) ex = u[64] ? `AEU_Q31_MIN : `AEU_Q31_MAX;
        issue(o, ix, o[5] ? ~sh : sh, 32'hFFFF_FFE0 | (o[5] ? sh : ~sh), 32'h0000_4000, 4'hC);
        chk("word", ex, dest);
        chk("ctl", {8'h0, ov33(t[64:32]) | ov33(u[64:32]), 23'h4000}, next_ctl);
    endtask
    task automatic t_half(input [1:0] ix, input [4:0] sh);
        logic signed [63:0] h;
        logic k;
        h = (i_pipe.acc[ix] >> sh) | (i_pipe.acc[ix][63] ? ~(64'hFFFF_FFFF_FFFF_FFFF >> sh) : 64'h0);
        k = h > 64'sd32767 || h < -64'sd32768;
        issue(`AEU_OP_H_S, ix, sh, 32'h0, 32'h0, 4'hC);
        chk("half", k ? (h[63] ? `AEU_H_MIN : `AEU_H_MAX) : h[31:0], dest);
        chk("ctl", {8'h0, k | (h[31] != i_pipe.acc[ix][63]), 23'h0}, next_ctl);
    endtask
    initial begin
        i_pipe.acc[0] = 64'h8123_4567_89AB_CDEF;
        i_pipe.acc[1] = 64'h0000_0000_FFFF_FFFF;
        i_pipe.acc[2] = 64'hFFFF_FFFF_0000_0000;
        i_pipe.acc[3] = 64'h0000_0000_0000_1234;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_field(6'd63, 32'hFFFF_FFFF);
        t_field(6'd10, 32'h0000_000A);
        t_field(6'd9, 32'hFFFF_FFEA);
        t_field(6'd0, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 6; k++) t_word(ops[k], 2'(i), i == 3 ? 5'd31 : (i == 0 ? 5'd4 : 5'd0));
        end
        t_half(2'd1, 5'd0);
        t_half(2'd2, 5'd0);
        t_half(2'd3, 5'd4);
        t_half(2'd0, 5'd31);
        issue(8'h40, 2'h0, 5'h0, 32'h0, 32'h0, 4'hA);
        @(posedge clock);
        impl <= 1'b0;
        issue(`AEU_OP_W, 2'h0, 5'h0, 32'h0, 32'h0, 4'hA);
        @(posedge clock);
        impl <= 1'b1;
        acc_ok <= 1'b0;
        issue(`AEU_OP_W, 2'h0, 5'h0, 32'h0, 32'h0, 4'h9);
        end_sim;
    end
endmodule // aeu_extract_unit_tb
`default_nettype wire
